// ===== src/mpwm_pkg.sv
// shared constants and carrier types for the multiphase pwm sequencer
// assumes analog comparators and threshold detectors deliver clean levels
package mpwm_pkg;
	localparam int SYS_CLK_HZ = 20000000;
	// default switching period in sys_clk cycles: 20 MHz / 250 kHz
	localparam int PERIOD_CYCLES_DEF = 80;
	localparam int PERIOD_WIDTH = 16;
	localparam int NUM_PHASES = 4;
	// cycles after reset release before the strap pins are sampled
	localparam int STRAP_SETTLE_CYCLES = 4;
	localparam logic [1:0] COUNT_TWO = 2'h0;
	localparam logic [1:0] COUNT_THREE = 2'h1;
	localparam logic [1:0] COUNT_FOUR = 2'h2;

	// analog monitor comparator outputs, all active high
	typedef struct packed {
		logic supplyAboveRise;
		logic supplyBelowFall;
		logic enableAboveRise;
		logic enableBelowFall;
		logic freqSetBelowDisable;
	} power_cmp_t;

	typedef struct packed {
		logic overVoltage;
		logic diffBelowUnder;
		logic diffAboveLimit;
	} out_cmp_t;

	typedef enum logic [1:0] {
		ST_STRAP = 2'b00,
		ST_OFF = 2'b01,
		ST_RUN = 2'b10
	} run_state_t;
endpackage

// ===== src/phase_channel.sv
// one output channel: terminate, forced off, comparator driven rise
// assumes termination pulses are one cycle and arrive once per cycle
`timescale 1ns/1ps
`default_nettype none
module phase_channel #(
	parameter int PERIOD_WIDTH = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// control
	input wire logic active,
	input wire logic terminate,
	input wire logic rampCross,
	input wire logic [PERIOD_WIDTH-1:0] forcedOffCycles,
	// outputs
	output logic drive,
	output logic sampleWindow
);
	logic [PERIOD_WIDTH-1:0] offCnt_q;
	logic drive_q;

	// counts down the forced off window after each falling edge
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			offCnt_q <= '0;
		else if (!active)
			offCnt_q <= '0;
		else if (terminate)
			offCnt_q <= forcedOffCycles;
		else if (offCnt_q != '0)
			offCnt_q <= offCnt_q - 1'b1;
	end

	// termination has priority so a late crossing never stretches a pulse
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			drive_q <= 1'b0;
		else if (!active || terminate)
			drive_q <= 1'b0;
		else if (offCnt_q == '0 && rampCross)
			drive_q <= 1'b1;
	end

	assign drive = drive_q;
	assign sampleWindow = (offCnt_q != '0);

	// a termination must open the off window and pull the output low
	property p_off_hold;
		@(posedge sys_clk) disable iff (rst)
		terminate && active |=> !drive_q && (offCnt_q != '0);
	endproperty
	a_off_hold: assert property (p_off_hold)
		else $error("forced off window missing");

	// no crossing may raise the output while the window is still open
	property p_no_early_rise;
		@(posedge sys_clk) disable iff (rst)
		!drive_q && (offCnt_q != '0) |=> !drive_q;
	endproperty
	a_no_early_rise: assert property (p_no_early_rise)
		else $error("output rose inside forced off time");
endmodule
`default_nettype wire

// ===== src/multiphase_pwm_sequencer.sv
// timing core of an interleaved multiphase buck controller
// assumes all inputs synchronous to sys_clk; analog thresholds outside
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - over-voltage latches crowbar output high
// - power good low below under or over limit
// - frequency-set pin low disables controller
// - enable rise starts soft start, fall disables
// - run only between supply power-on thresholds
// - third output strapped high: two channels
// - only fourth strapped high: three channels
// - no strap: four channels by default
// - cycle begins when first output terminates
// - four channels: terminations a quarter apart
// - two channels: second ends half later
// - three channels: terminations a third apart
// - forced off at least quarter cycle
// - after forced off, ramp crossing raises output
// - output high until its next termination
// - current sampled only during forced off
module multiphase_pwm_sequencer #(
	parameter int PERIOD_CYCLES = mpwm_pkg::PERIOD_CYCLES_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// analog monitors
	input wire mpwm_pkg::power_cmp_t powerCmp,
	input wire mpwm_pkg::out_cmp_t outCmp,
	// per-channel ramp crossing from the comparators
	input wire logic [mpwm_pkg::NUM_PHASES-1:0] rampCross,
	// strap sense on the third and fourth output pins
	input wire logic strap3In,
	input wire logic strap4In,
	// phase outputs with enables; strapped pins are never driven
	output logic phase_drive_1,
	output logic phase_drive_2,
	output logic phase_drive_3,
	output logic phase_drive_4,
	output logic [mpwm_pkg::NUM_PHASES-1:0] phaseOe,
	// current sample windows
	output logic [mpwm_pkg::NUM_PHASES-1:0] sampleWindow,
	// status and protection
	output logic softStartPulse,
	output logic running,
	output logic [1:0] channelCount,
	output logic overvoltage_crowbar_out,
	output logic power_good_out,
	output logic powerGoodOe
);
	import mpwm_pkg::*;

	localparam int PW = PERIOD_WIDTH;
	localparam logic [PW-1:0] PERIOD_M1 = PW'(PERIOD_CYCLES - 1);
	localparam logic [PW-1:0] QUARTER = PW'(PERIOD_CYCLES / 4);
	localparam logic [PW-1:0] HALF = PW'(PERIOD_CYCLES / 2);
	localparam logic [PW-1:0] THIRD = PW'(PERIOD_CYCLES / 3);
	localparam logic [PW-1:0] THIRD2 = PW'((2 * PERIOD_CYCLES) / 3);
	localparam logic [PW-1:0] QUARTER3 = PW'((3 * PERIOD_CYCLES) / 4);
	localparam logic [2:0] SETTLE = 3'(STRAP_SETTLE_CYCLES);
	// distance in cycles from the first to the second termination with four channels
	localparam int QDELAY = PERIOD_CYCLES / 4;

	// the counter must hold the period and a quarter must be nonzero
	if (PERIOD_CYCLES < 8 || PERIOD_CYCLES >= (1 << PW))
	begin : gen_bad_period
		$error("PERIOD_CYCLES out of range");
	end

	run_state_t state_q;
	logic [2:0] settle_q;
	logic [1:0] count_q;
	logic supplyOk_q;
	logic enableOn_q;
	logic [PW-1:0] phaseCnt_q;
	logic crowbar_q;
	logic powerGood_q;
	logic ssPulse_q;
	logic runOk;
	logic [NUM_PHASES-1:0] active;
	logic [NUM_PHASES-1:0] terminate;
	logic [NUM_PHASES-1:0] drive;

	// supply gate with hysteresis between the two power-on thresholds
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			supplyOk_q <= 1'b0;
		else if (powerCmp.supplyBelowFall)
			supplyOk_q <= 1'b0;
		else if (powerCmp.supplyAboveRise)
			supplyOk_q <= 1'b1;
	end

	// enable hysteresis: rising threshold arms, falling one disarms
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			enableOn_q <= 1'b0;
		else if (powerCmp.enableBelowFall)
			enableOn_q <= 1'b0;
		else if (powerCmp.enableAboveRise)
			enableOn_q <= 1'b1;
	end

	assign runOk = supplyOk_q && enableOn_q &&
		!powerCmp.freqSetBelowDisable;

	// strap sampled once, after a settle delay, then held until reset
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ST_STRAP;
			settle_q <= 3'h0;
			count_q <= COUNT_FOUR;
			ssPulse_q <= 1'b0;
		end
		else
		begin
			ssPulse_q <= 1'b0;
			unique case (state_q)
				ST_STRAP:
				begin
					if (settle_q == SETTLE)
					begin
						state_q <= ST_OFF;
						if (strap3In)
							count_q <= COUNT_TWO;
						else if (strap4In)
							count_q <= COUNT_THREE;
						else
							count_q <= COUNT_FOUR;
					end
					else
						settle_q <= settle_q + 3'h1;
				end
				ST_OFF:
				begin
					if (runOk)
					begin
						state_q <= ST_RUN;
						ssPulse_q <= 1'b1;
					end
				end
				ST_RUN:
				begin
					if (!runOk)
						state_q <= ST_OFF;
				end
				default:
					state_q <= ST_STRAP;
			endcase
		end
	end

	// cycle counter; zero marks the first phase's termination
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			phaseCnt_q <= '0;
		else if (state_q != ST_RUN)
			phaseCnt_q <= '0;
		else if (phaseCnt_q == PERIOD_M1)
			phaseCnt_q <= '0;
		else
			phaseCnt_q <= phaseCnt_q + 1'b1;
	end

	// termination instants per channel count; integer division trades
	// up to one cycle of skew for a single shared counter
	always_comb
	begin
		terminate = '0;
		active = '0;
		if (state_q == ST_RUN)
		begin
			terminate[0] = (phaseCnt_q == '0);
			unique case (count_q)
				COUNT_TWO:
				begin
					active = 4'h3;
					terminate[1] = (phaseCnt_q == HALF);
				end
				COUNT_THREE:
				begin
					active = 4'h7;
					terminate[1] = (phaseCnt_q == THIRD);
					terminate[2] = (phaseCnt_q == THIRD2);
				end
				default:
				begin
					active = 4'hf;
					terminate[1] = (phaseCnt_q == QUARTER);
					terminate[2] = (phaseCnt_q == HALF);
					terminate[3] = (phaseCnt_q == QUARTER3);
				end
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_PHASES; g++)
		begin : gen_ch
			phase_channel #(
				.PERIOD_WIDTH(PW)
			) u_ch (
				.sys_clk(sys_clk),
				.rst(rst),
				.active(active[g]),
				.terminate(terminate[g]),
				.rampCross(rampCross[g]),
				.forcedOffCycles(QUARTER),
				.drive(drive[g]),
				.sampleWindow(sampleWindow[g])
			);
		end
	endgenerate

	assign phase_drive_1 = drive[0];
	assign phase_drive_2 = drive[1];
	assign phase_drive_3 = drive[2];
	assign phase_drive_4 = drive[3];
	// strapped pins stay released so the strap level is never fought
	assign phaseOe = active | ((state_q == ST_STRAP) ? 4'h0 : 4'h3);

	// crowbar latches until reset; nothing else clears it
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			crowbar_q <= 1'b0;
		else if (outCmp.overVoltage)
			crowbar_q <= 1'b1;
	end

	// power good also low while not running
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			powerGood_q <= 1'b0;
		else
			powerGood_q <= (state_q == ST_RUN) && !outCmp.diffBelowUnder &&
				!outCmp.diffAboveLimit;
	end

	assign overvoltage_crowbar_out = crowbar_q;
	assign power_good_out = 1'b0;
	assign powerGoodOe = !powerGood_q;
	assign softStartPulse = ssPulse_q;
	assign running = (state_q == ST_RUN);
	assign channelCount = count_q;

	property p_crowbar;
		@(posedge sys_clk) disable iff (rst)
		outCmp.overVoltage |=> crowbar_q [*3];
	endproperty
	a_crowbar: assert property (p_crowbar)
		else $error("crowbar did not latch");

	property p_power_good_out;
		@(posedge sys_clk) disable iff (rst)
		(outCmp.diffBelowUnder || outCmp.diffAboveLimit) |=> powerGoodOe;
	endproperty
	a_power_good_out: assert property (p_power_good_out)
		else $error("power good not pulled low");

	property p_fsdis;
		@(posedge sys_clk) disable iff (rst)
		powerCmp.freqSetBelowDisable && state_q == ST_RUN |=>
			state_q == ST_OFF;
	endproperty
	a_fsdis: assert property (p_fsdis)
		else $error("disable pin ignored");

	property p_ss;
		@(posedge sys_clk) disable iff (rst)
		$rose(running) |-> softStartPulse;
	endproperty
	a_ss: assert property (p_ss)
		else $error("no soft start pulse");

	property p_supply;
		@(posedge sys_clk) disable iff (rst)
		!supplyOk_q |=> !running;
	endproperty
	a_supply: assert property (p_supply)
		else $error("running without supply");

	property p_idle_low;
		@(posedge sys_clk) disable iff (rst)
		!running |=> (drive == 4'h0);
	endproperty
	a_idle_low: assert property (p_idle_low)
		else $error("output high while idle");

	property p_strap_fixed;
		@(posedge sys_clk) disable iff (rst)
		state_q != ST_STRAP |=> $stable(count_q);
	endproperty
	a_strap_fixed: assert property (p_strap_fixed)
		else $error("channel count changed");

	property p_two_ch;
		@(posedge sys_clk) disable iff (rst)
		count_q == COUNT_TWO |-> drive[3:2] == 2'h0;
	endproperty
	a_two_ch: assert property (p_two_ch)
		else $error("inactive channel driven");

	// looks back from the second termination so that a short stop and
	// restart of the run cannot raise a false alarm
	property p_spacing;
		@(posedge sys_clk) disable iff (rst)
		terminate[1] && count_q == COUNT_FOUR |->
			$past(terminate[0], QDELAY);
	endproperty
	a_spacing: assert property (p_spacing)
		else $error("second phase not a quarter later");
endmodule
`default_nettype wire

// ===== tb/driver_model.sv
// phase pin resolution and edge timing seen by the driver inputs
// assumes open pins sit at the driver's weak pull-down
`timescale 1ns/1ps
`default_nettype none
module driver_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// design side and board straps
	input wire logic [3:0] drv,
	input wire logic [3:0] oe,
	input wire logic [3:0] tie,
	// pin levels and edge times in cycles
	output logic [3:0] pin,
	output var int fallAt [4],
	output var int lowLen [4],
	output var int lastPeriod
);
	int cyc = 0;
	logic [3:0] prev;
	// strapped pin reads supply, open pin the pull-down
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			pin[i] = oe[i] ? drv[i] : tie[i];
	end
	// stamp edges so the bench can judge spacing afterwards
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		prev <= rst ? 4'h0 : pin;
		for (int i = 0; i < 4; i++)
		begin
			if (prev[i] && !pin[i])
				fallAt[i] <= cyc;
			if (!prev[i] && pin[i] && !rst)
				lowLen[i] <= cyc - fallAt[i];
		end
		if (prev[0] && !pin[0])
			lastPeriod <= cyc - fallAt[0];
	end
endmodule
`default_nettype wire

// ===== tb/multiphase_pwm_sequencer_test.sv
// bench for the sequencer: strap modes, spacing, gating, protection
// assumes driver_model resolves the phase pins
`timescale 1ns/1ps
`default_nettype none
module multiphase_pwm_sequencer_test;
	import mpwm_pkg::*;
	localparam int P = 16;
	logic sys_clk = 0;
	logic rst = 1;
	power_cmp_t powerCmp = '0;
	out_cmp_t outCmp = '0;
	logic [3:0] rampCross = 4'h0;
	logic [3:0] tie = 4'h0;
	logic [3:0] drv, pin, phaseOe, sampleWindow;
	logic softStartPulse, running, crowbar, pgOut, powerGoodOe;
	logic [1:0] channelCount;
	logic sawStart = 0;
	int fallAt [4];
	int lowLen [4];
	int lastPeriod;
	int n_fail = 0;
	int n_checks = 0;
	// 50 ns period
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (softStartPulse === 1'b1)
			sawStart <= 1'b1;
	multiphase_pwm_sequencer #(.PERIOD_CYCLES(P)) u_dut (
		.sys_clk(sys_clk), .rst(rst), .powerCmp(powerCmp),
		.outCmp(outCmp), .rampCross(rampCross),
		.strap3In(pin[2]), .strap4In(pin[3]),
		.phase_drive_1(drv[0]), .phase_drive_2(drv[1]),
		.phase_drive_3(drv[2]), .phase_drive_4(drv[3]),
		.phaseOe(phaseOe), .sampleWindow(sampleWindow),
		.softStartPulse(softStartPulse), .running(running),
		.channelCount(channelCount),
		.overvoltage_crowbar_out(crowbar),
		.power_good_out(pgOut), .powerGoodOe(powerGoodOe));
	driver_model u_drv (
		.sys_clk(sys_clk), .rst(rst), .drv(drv), .oe(phaseOe),
		.tie(tie), .pin(pin), .fallAt(fallAt), .lowLen(lowLen),
		.lastPeriod(lastPeriod));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// bounded wait for run entry after the gating inputs allow it
	task automatic wait_run();
		for (int k = 0; k < 20 && running !== 1'b1; k++)
			tick(1);
		check(running, 1'b1);
	endtask
	function automatic int gap(input int a, input int b);
		return ((b - a) % P + P) % P;
	endfunction
	task automatic give_verdict();
		if (n_fail == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watchdog sized well past the whole sequence
	initial
	begin
		#(50 * 40000);
		n_fail++;
		give_verdict();
	end
	initial
	begin
		logic [3:0] ties [3];
		logic [1:0] cnt [3];
		int stp [3];
		int nph [3];
		logic [4:0] off [3];
		logic [3:0] oes [3];
		ties = '{4'h4, 4'h8, 4'h0};
		oes = '{4'h3, 4'h7, 4'hf};
		cnt = '{COUNT_TWO, COUNT_THREE, COUNT_FOUR};
		stp = '{P / 2, P / 3, P / 4};
		nph = '{2, 3, 4};
		// strap modes end with four channels, used afterwards
		for (int m = 0; m < 3; m++)
		begin
			tie = ties[m];
			powerCmp = '0;
			rampCross = 4'hf;
			rst = 1'b1;
			tick(10);
			rst = 1'b0;
			tick(8);
			check(channelCount, cnt[m]);
			check({running, crowbar, powerGoodOe}, 3'h1);
			check(drv, 4'h0);
			sawStart = 1'b0;
			powerCmp = 5'h14;
			wait_run();
			tick(3 * P);
			check(sawStart, 1'b1);
			check(phaseOe, oes[m]);
			check(lastPeriod, P);
			for (int i = 1; i < nph[m]; i++)
				check(gap(fallAt[i-1], fallAt[i]), stp[m]);
			check(lowLen[0] >= P / 4, 1'b1);
			check(lowLen[0] <= P / 4 + 2, 1'b1);
			tie = 4'h0;
			tick(5);
			check(channelCount, cnt[m]);
		end
		// high output holds without crossing; low output waits for one
		@(posedge pin[0]);
		#1;
		check(sampleWindow[0], 1'b0);
		tick(1);
		rampCross = 4'h0;
		tick(P / 2);
		check(pin[0], 1'b1);
		@(negedge pin[0]);
		tick(2);
		check(sampleWindow[0], 1'b1);
		tick(P);
		check(pin[0], 1'b0);
		rampCross = 4'hf;
		// frequency-set low, enable fall, supply fall each stop the run
		off = '{5'h15, 5'h12, 5'h0c};
		for (int d = 0; d < 3; d++)
		begin
			powerCmp = off[d];
			tick(3);
			check({running, drv}, 5'h00);
			powerCmp = 5'h14;
			wait_run();
		end
		// power good follows the diff window; crowbar latches
		tick(2);
		check({pgOut, powerGoodOe}, 2'h0);
		outCmp = 3'h2;
		tick(2);
		check({pgOut, powerGoodOe}, 2'h1);
		outCmp = 3'h1;
		tick(2);
		check({pgOut, powerGoodOe}, 2'h1);
		outCmp = 3'h4;
		tick(2);
		outCmp = 3'h0;
		tick(5);
		check(crowbar, 1'b1);
		give_verdict();
	end
endmodule
`default_nettype wire
